// ==== hw/ser_pkg.sv ====
// Purpose: Constants for the status event and service request block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bit positions follow the eight-bit binary weighting.
// What this block does
// - Event log clears on its query and on clear-status; power-up leaves only bit 7 set.
// - Writing zero clears either enable mask; power-up clears both masks.
// - Status byte has no direct clear; it follows its event sources.
// - Event log bit 7 flags an off-to-on transition.
// - Event log bit 5 flags an uninterpretable command.
// - Event log bit 4 flags a request beyond the device's capabilities.
// - Event log bit 2 flags response data lost to a full queue.
// - After operation-complete command, bit 0 sets once nothing is pending.
// - Event mask written and read by commands; log query reads and clears atomically.
// - Status byte summary bits are combinational and never latch.
// - Status bit 5 is high when any enabled event bit is set.
// - Status bit 6 is high when any enabled summary bit is set.
// - Rising enabled summary raises the service request line.
// - Serial poll clears request-service but not master summary.
// - Status-byte query returns all bits including master summary, clearing nothing.
// - Master summary drops only when no enabled summary bit remains.
// - Status bit 7 shows sample heater ramp done.
// - Status bit 4 shows any input overload or range fault.
// - Status bit 3 shows alarm while alarm display is enabled.
// - Status bit 2 shows a valid measurement reading.
// - Status bit 1 shows a valid control reading.
// - Status bit 0 shows warm-up heater ramp done.
// - Event bits latch; repeats are ignored until cleared.
// - After a poll, a repeat on the same summary bit raises no request.
// - Service request mask written and read by its own commands.
package ser_pkg;
    localparam int EVLOG_PON_BIT = 7;
    localparam int EVLOG_CME_BIT = 5;
    localparam int EVLOG_EXE_BIT = 4;
    localparam int EVLOG_QYE_BIT = 2;
    localparam int EVLOG_OPC_BIT = 0;
    localparam int SBYTE_SAMPLE_RAMP_BIT = 7;
    localparam int SBYTE_RQS_BIT = 6;
    localparam int SBYTE_ESB_BIT = 5;
    localparam int SBYTE_OVERLOAD_BIT = 4;
    localparam int SBYTE_ALARM_BIT = 3;
    localparam int SBYTE_MEAS_VALID_BIT = 2;
    localparam int SBYTE_CTRL_VALID_BIT = 1;
    localparam int SBYTE_WARMUP_RAMP_BIT = 0;
    localparam logic [7:0] EVLOG_RST = 8'h80;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] SRE_WR_MASK = 8'hbf;
endpackage

// ==== hw/ser_status_core.sv ====
// Purpose: Standard event log, enable masks, status byte and service request.
// Assumes: All inputs come from logic on ref_clk_i; strobes are one-cycle pulses.
// Notes: Only one query strobe per cycle is expected; a fixed priority settles overlap.
`timescale 1ns/1ps
`default_nettype none
module ser_status_core
    import ser_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_err_i,
    input wire logic exe_err_i,
    input wire logic qry_err_i,
    input wire logic opc_cmd_i,
    input wire logic ops_pending_i,
    input wire logic evlog_query_i,
    input wire logic cls_i,
    input wire logic ese_wr_i,
    input wire logic ese_query_i,
    input wire logic sre_wr_i,
    input wire logic sre_query_i,
    input wire logic sbyte_query_i,
    input wire logic [7:0] param_i,
    input wire logic serial_poll_i,
    input wire logic sample_heater_ramp_done_i,
    input wire logic warmup_heater_ramp_done_i,
    input wire logic current_source_overload_i,
    input wire logic common_mode_overload_i,
    input wire logic differential_overload_i,
    input wire logic mixer_overload_i,
    input wire logic [3:0] range_fault_i,
    input wire logic alarm_i,
    input wire logic alarm_visible_i,
    input wire logic measure_reading_valid_i,
    input wire logic control_reading_valid_i,
    output logic [7:0] resp_data_o,
    output logic resp_valid_o,
    output logic [7:0] poll_byte_o,
    output logic poll_valid_o,
    output logic srq_o
);

    logic [7:0] evlog_r;
    logic [7:0] ese_r;
    logic [7:0] sre_r;
    logic [7:0] evlog_set;
    logic [7:0] sbyte_sum;
    logic [7:0] en_sum;
    logic [7:0] en_sum_q_r;
    logic [7:0] en_rise;
    logic opc_armed_r;
    logic opc_done;
    logic mss;
    logic rqs_r;
    logic evlog_clear;
    logic sensor_overload_flag;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    assign opc_done = opc_armed_r & ~ops_pending_i;
    assign evlog_clear = evlog_query_i | cls_i;

    always_comb begin
        evlog_set = 8'h00;
        evlog_set[EVLOG_CME_BIT] = cmd_err_i;
        evlog_set[EVLOG_EXE_BIT] = exe_err_i;
        evlog_set[EVLOG_QYE_BIT] = qry_err_i;
        evlog_set[EVLOG_OPC_BIT] = opc_done;
    end

    // Events in the clearing cycle survive the clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            evlog_r <= EVLOG_RST;
        end else if (evlog_clear) begin
            evlog_r <= evlog_set;
        end else begin
            evlog_r <= evlog_r | evlog_set;
        end
    end

    // Clear-status also drops a pending operation-complete wait
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            opc_armed_r <= 1'b0;
        end else if (cls_i) begin
            opc_armed_r <= 1'b0;
        end else if (opc_cmd_i) begin
            opc_armed_r <= 1'b1;
        end else if (opc_done) begin
            opc_armed_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ese_r <= ESE_RST;
        end else if (ese_wr_i) begin
            ese_r <= param_i;
        end
    end

    // Bit 6 cannot enable itself
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sre_r <= SRE_RST;
        end else if (sre_wr_i) begin
            sre_r <= param_i & SRE_WR_MASK;
        end
    end

    assign sensor_overload_flag = current_source_overload_i | common_mode_overload_i |
        differential_overload_i | mixer_overload_i | (|range_fault_i);

    always_comb begin
        sbyte_sum = 8'h00;
        sbyte_sum[SBYTE_SAMPLE_RAMP_BIT] = sample_heater_ramp_done_i;
        sbyte_sum[SBYTE_ESB_BIT] = |(evlog_r & ese_r);
        sbyte_sum[SBYTE_OVERLOAD_BIT] = sensor_overload_flag;
        sbyte_sum[SBYTE_ALARM_BIT] = alarm_i & alarm_visible_i;
        sbyte_sum[SBYTE_MEAS_VALID_BIT] = measure_reading_valid_i;
        sbyte_sum[SBYTE_CTRL_VALID_BIT] = control_reading_valid_i;
        sbyte_sum[SBYTE_WARMUP_RAMP_BIT] = warmup_heater_ramp_done_i;
    end

    assign en_sum = sbyte_sum & sre_r;
    assign mss = |en_sum;

    // Per-bit edge so a held bit cannot re-request after a poll
    assign en_rise = en_sum & ~en_sum_q_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            en_sum_q_r <= 8'h00;
        end else begin
            en_sum_q_r <= en_sum;
        end
    end

    // A new rise beats a poll in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rqs_r <= 1'b0;
        end else if (|en_rise) begin
            rqs_r <= 1'b1;
        end else if (serial_poll_i) begin
            rqs_r <= 1'b0;
        end
    end

    assign srq_o = rqs_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            poll_byte_o <= 8'h00;
            poll_valid_o <= 1'b0;
        end else begin
            poll_valid_o <= serial_poll_i;
            if (serial_poll_i) begin
                poll_byte_o <= sbyte_sum | {1'b0, rqs_r, 6'h00};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            resp_data_o <= 8'h00;
            resp_valid_o <= 1'b0;
        end else begin
            resp_valid_o <= evlog_query_i | ese_query_i | sre_query_i | sbyte_query_i;
            if (evlog_query_i) begin
                resp_data_o <= evlog_r;
            end else if (ese_query_i) begin
                resp_data_o <= ese_r;
            end else if (sre_query_i) begin
                resp_data_o <= sre_r;
            end else if (sbyte_query_i) begin
                resp_data_o <= sbyte_sum | {1'b0, mss, 6'h00};
            end
        end
    end

    sequence opc_arm_s;
        opc_cmd_i && !cls_i;
    endsequence

    sequence opc_idle_s;
        !ops_pending_i && !cls_i && !evlog_query_i && !opc_cmd_i;
    endsequence

    sequence no_clear_s;
        !evlog_query_i && !cls_i;
    endsequence

    pon_after_reset_a: assert property (
        $past(rst_n_i) == 1'b0 |-> evlog_r == EVLOG_RST)
        else $error("Power-on flag missing after reset");

    query_clears_log_a: assert property (
        evlog_query_i && !cmd_err_i && !exe_err_i && !qry_err_i && !opc_armed_r |=> evlog_r == 8'h00)
        else $error("Event log not cleared by query");

    query_returns_log_a: assert property (
        evlog_query_i |=> resp_valid_o && resp_data_o == $past(evlog_r))
        else $error("Event log query returned wrong value");

    cmd_err_latch_a: assert property (
        cmd_err_i |=> evlog_r[EVLOG_CME_BIT])
        else $error("Command error not latched");

    exe_err_latch_a: assert property (
        exe_err_i |=> evlog_r[EVLOG_EXE_BIT])
        else $error("Execution error not latched");

    qry_err_latch_a: assert property (
        qry_err_i |=> evlog_r[EVLOG_QYE_BIT])
        else $error("Query error not latched");

    event_bits_hold_a: assert property (
        no_clear_s |=> (evlog_r & $past(evlog_r)) == $past(evlog_r))
        else $error("Latched event bit lost without clear");

    opc_sets_bit_a: assert property (
        opc_arm_s ##1 opc_idle_s |=> evlog_r[EVLOG_OPC_BIT])
        else $error("Operation complete bit not set");

    mask_write_a: assert property (
        ese_wr_i |=> ese_r == $past(param_i))
        else $error("Enable mask write lost");

    sre_mask_write_a: assert property (
        sre_wr_i |=> sre_r == ($past(param_i) & SRE_WR_MASK))
        else $error("Service request mask write lost");

    mask_zero_a: assert property (
        ese_wr_i && param_i == 8'h00 |=> ese_r == 8'h00)
        else $error("Event mask not cleared by zero");

    sre_write_a: assert property (
        sre_wr_i && !ese_query_i && !evlog_query_i ##1 sre_query_i && !evlog_query_i && !ese_query_i
        |=> resp_data_o == $past(sre_r))
        else $error("Service request mask readback wrong");

    ese_readback_a: assert property (
        ese_query_i && !evlog_query_i |=> resp_valid_o && resp_data_o == $past(ese_r))
        else $error("Event mask readback wrong");

    stb_query_mss_a: assert property (
        sbyte_query_i && !evlog_query_i && !ese_query_i && !sre_query_i
        |=> resp_data_o[SBYTE_RQS_BIT] == $past(|(sbyte_sum & sre_r)) &&
            resp_data_o[SBYTE_ESB_BIT] == $past(|(evlog_r & ese_r)))
        else $error("Status byte query wrong");

    mss_drops_a: assert property (
        sbyte_query_i && !evlog_query_i && !ese_query_i && !sre_query_i && (sbyte_sum & sre_r) == 8'h00
        |=> !resp_data_o[SBYTE_RQS_BIT])
        else $error("Master summary set without enabled bit");

    rise_raises_srq_a: assert property (
        |(sbyte_sum & sre_r & ~en_sum_q_r) |=> srq_o)
        else $error("Service request not raised");

    poll_clears_rqs_a: assert property (
        serial_poll_i && !(|en_rise) |=> !srq_o && poll_byte_o[SBYTE_RQS_BIT] == $past(rqs_r))
        else $error("Serial poll did not clear request");

    poll_answer_a: assert property (
        serial_poll_i |=> poll_valid_o)
        else $error("Serial poll not answered");

    no_repeat_srq_a: assert property (
        !srq_o && !(|en_rise) |=> !srq_o)
        else $error("Service request without new rise");

    clear_drops_esb_a: assert property (
        cls_i && !cmd_err_i && !exe_err_i && !qry_err_i && !opc_armed_r |=> !sbyte_sum[SBYTE_ESB_BIT])
        else $error("Event summary did not drop after clear");

    cls_clears_log_a: assert property (
        cls_i && !cmd_err_i && !exe_err_i && !qry_err_i && !opc_armed_r |=> evlog_r == 8'h00)
        else $error("Clear-status left event bits");

    opc_waits_a: assert property (
        !evlog_r[EVLOG_OPC_BIT] && ops_pending_i |=> !evlog_r[EVLOG_OPC_BIT])
        else $error("Operation complete set while pending");

    pon_only_reset_a: assert property (
        !evlog_r[EVLOG_PON_BIT] |=> !evlog_r[EVLOG_PON_BIT])
        else $error("Power-on flag set outside reset");

    esb_summary_a: assert property (
        evlog_r[EVLOG_CME_BIT] && ese_r[EVLOG_CME_BIT] |-> sbyte_sum[SBYTE_ESB_BIT])
        else $error("Event summary bit missing");

    sample_ramp_bit_a: assert property (
        sample_heater_ramp_done_i |-> sbyte_sum[SBYTE_SAMPLE_RAMP_BIT])
        else $error("Sample ramp bit missing");

    overload_bit_a: assert property (
        (|range_fault_i) || mixer_overload_i |-> sbyte_sum[SBYTE_OVERLOAD_BIT])
        else $error("Overload bit missing");

    alarm_hidden_a: assert property (
        alarm_i && !alarm_visible_i |-> !sbyte_sum[SBYTE_ALARM_BIT])
        else $error("Hidden alarm shown");

endmodule
`default_nettype wire

// ==== tb/ser_host_model.sv ====
// Purpose: Bus controller that serial-polls the core on a service request.
// Assumes: Drives on the falling edge, like the bench.
// Notes: A poll delay lets the bench act as a slow controller.
`timescale 1ns/1ps
`default_nettype none
module ser_host_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic poll_en_i,
    input wire logic [3:0] poll_delay_i,
    input wire logic srq_i,
    input wire logic poll_valid_i,
    input wire logic [7:0] poll_byte_i,
    output logic serial_poll_o,
    output logic [7:0] poll_byte_o,
    output logic [7:0] poll_count_o
);
    logic [3:0] wait_r;
    logic busy_r;
    initial serial_poll_o = 1'b0;
    always @(negedge ref_clk_i) begin
        serial_poll_o <= 1'b0;
        if (!rst_n_i) begin
            wait_r <= 4'h0;
            busy_r <= 1'b0;
            poll_count_o <= 8'h00;
            poll_byte_o <= 8'h00;
        end else if (poll_valid_i) begin
            poll_byte_o <= poll_byte_i;
            poll_count_o <= poll_count_o + 8'h01;
            busy_r <= 1'b0;
        end else if (poll_en_i && srq_i && !busy_r) begin
            // Slow controller: let the request stand first
            if (wait_r >= poll_delay_i) begin
                serial_poll_o <= 1'b1;
                busy_r <= 1'b1;
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/status_event_service_request_test.sv ====
// Purpose: Self-checking bench for the status and service request core.
// Assumes: Inputs change on the falling edge only.
// Notes: Queries are checked in the cycle their answer stands.
`timescale 1ns/1ps
`default_nettype none
module status_event_service_request_test;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] qs = 4'h0;
    logic [1:0] ws = 2'h0;
    logic [4:0] ev = 5'h00;
    logic pend = 1'b0;
    logic pen = 1'b0;
    logic [7:0] prm = 8'h00;
    logic [13:0] src = 14'h0000;
    logic spoll, rval, pval, srq;
    logic [7:0] rdat, pbyte, hbyte, npoll;
    int failures = 0;
    int n_compared = 0;
    int i;
    initial forever #5 ref_clk_i = ~ref_clk_i;
    ser_status_core u_ser_status_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .cmd_err_i(ev[0]), .exe_err_i(ev[1]), .qry_err_i(ev[2]), .opc_cmd_i(ev[3]), .cls_i(ev[4]),
        .ops_pending_i(pend), .evlog_query_i(qs[0]), .ese_query_i(qs[1]), .sre_query_i(qs[2]),
        .sbyte_query_i(qs[3]), .ese_wr_i(ws[0]), .sre_wr_i(ws[1]), .param_i(prm), .serial_poll_i(spoll),
        .sample_heater_ramp_done_i(src[0]), .warmup_heater_ramp_done_i(src[1]),
        .current_source_overload_i(src[2]), .common_mode_overload_i(src[3]),
        .differential_overload_i(src[4]), .mixer_overload_i(src[5]), .alarm_i(src[6]),
        .alarm_visible_i(src[7]), .measure_reading_valid_i(src[8]), .control_reading_valid_i(src[9]),
        .range_fault_i(src[13:10]), .resp_data_o(rdat), .resp_valid_o(rval), .poll_byte_o(pbyte),
        .poll_valid_o(pval), .srq_o(srq));
    ser_host_model u_ser_host_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .poll_en_i(pen),
        .poll_delay_i(4'h2), .srq_i(srq), .poll_valid_i(pval), .poll_byte_i(pbyte),
        .serial_poll_o(spoll), .poll_byte_o(hbyte), .poll_count_o(npoll));
    task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic q(input int k, input logic [7:0] e);
        qs[k] = 1'b1;
        @(negedge ref_clk_i);
        qs[k] = 1'b0;
        ck("resp", e, (rval === 1'b1) ? rdat : 8'hzz);
    endtask
    task automatic w(input int k, input logic [7:0] d);
        ws[k] = 1'b1;
        prm = d;
        @(negedge ref_clk_i);
        ws[k] = 1'b0;
    endtask
    task automatic p(input int k);
        ev[k] = 1'b1;
        @(negedge ref_clk_i);
        ev[k] = 1'b0;
    endtask
    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic logic [7:0] exp_src(input int k);
        case (k)
            0: return 8'h80;
            1: return 8'h01;
            2, 3, 4, 5, 10, 11, 12, 13: return 8'h10;
            8: return 8'h04;
            9: return 8'h02;
            14: return 8'h08;
            default: return 8'h00;
        endcase
    endfunction
    task automatic srq_poll(input logic [7:0] e);
        logic [7:0] n0;
        @(negedge ref_clk_i);
        n0 = npoll;
        ck("srq", 8'h01, {7'h00, srq});
        // Wait for this poll, not an earlier one
        for (i = 0; i < 20 && npoll == n0; i++) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        ck("poll", e, hbyte);
        ck("srq", 8'h00, {7'h00, srq});
    endtask
    initial begin
        // Long enough for every scenario, short enough to cut a hang
        #20000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        q(0, 8'h80);
        q(0, 8'h00);
        q(1, 8'h00);
        q(2, 8'h00);
        p(0);
        p(2);
        p(1);
        p(0);
        q(0, 8'h34);
        pend = 1'b1;
        p(3);
        repeat (3) @(negedge ref_clk_i);
        q(0, 8'h00);
        pend = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        q(0, 8'h01);
        w(0, 8'h20);
        q(1, 8'h20);
        w(1, 8'hff);
        q(2, 8'hbf);
        q(3, 8'h00);
        pen = 1'b1;
        p(0);
        srq_poll(8'h60);
        ck("poll", 8'h60, hbyte);
        ck("srq", 8'h00, {7'h00, srq});
        q(3, 8'h60);
        p(0);
        repeat (4) @(negedge ref_clk_i);
        ck("srq", 8'h00, {7'h00, srq});
        w(1, 8'h00);
        q(3, 8'h20);
        q(2, 8'h00);
        w(1, 8'h20);
        q(3, 8'h60);
        p(4);
        q(3, 8'h00);
        p(0);
        srq_poll(8'h60);
        q(0, 8'h20);
        q(3, 8'h00);
        w(0, 8'h00);
        q(1, 8'h00);
        for (int k = 0; k < 15; k++) begin
            src = (k == 14) ? 14'h00c0 : (14'h0001 << k);
            @(negedge ref_clk_i);
            q(3, exp_src(k));
        end
        print_verdict();
    end
endmodule
`default_nettype wire
